// ===== pcsm_consts.svh
// Constants for the program sequencing and data memory map block.
// Assumes inclusion by bare name from the package and the design module.
`ifndef PCSM_CONSTS_SVH
`define PCSM_CONSTS_SVH
`define PCSM_PC_W        13
`define PCSM_PC_RESET    13'h0000
`define PCSM_CALL_LIMIT  13'h07ff
`define PCSM_SP_W        4
`define PCSM_SP_RESET    4'h5
`define PCSM_SP_HANG     4'h6
`define PCSM_RAS_DEPTH   5
`define PCSM_ICS_DEPTH   3
`define PCSM_CTX_W       6
`define PCSM_SYS_LO      7'h74
`define PCSM_DBF_LO      7'h0c
`define PCSM_DBF_HI      7'h0f
`define PCSM_DBF_RESET   16'h0320
`define PCSM_PORT_A      7'h6f
`define PCSM_PORT_LO     7'h70
`define PCSM_PORT_HI     7'h73
`define PCSM_RP_OFS      4'hc
`define PCSM_BANK_OFS    4'h9
`define PCSM_PSW_OFS     4'hf
`define PCSM_ROW_SYS     3'h7
`define PCSM_APB_CTRL    12'h000
`define PCSM_APB_CMD     12'h004
`define PCSM_APB_PC      12'h008
`define PCSM_APB_STAT    12'h00c
`define PCSM_APB_MEMA    12'h010
`define PCSM_APB_MEMD    12'h014
`endif

// ===== pcsm_pkg.sv
// Types shared by the program sequencing block and its bench.
// Assumes the constants header is on the include path.
`include "pcsm_consts.svh"
package pcsm_pkg;
	typedef enum logic [3:0] {
		PCSM_OP_NONE    = 4'h0,
		PCSM_OP_CALL    = 4'h1,
		PCSM_OP_ICALL   = 4'h2,
		PCSM_OP_TRD1    = 4'h3,
		PCSM_OP_TRD2    = 4'h4,
		PCSM_OP_PUSH    = 4'h5,
		PCSM_OP_POP     = 4'h6,
		PCSM_OP_RET     = 4'h7,
		PCSM_OP_RETURN_AND_SKIP   = 4'h8,
		PCSM_OP_INT     = 4'h9,
		PCSM_OP_IRET    = 4'ha,
		PCSM_OP_IBR     = 4'hb,
		PCSM_OP_STEP    = 4'hc
	} pcsm_op_t;
	typedef struct packed {
		logic       wide_rom;
		logic       two_banks;
	} pcsm_cfg_t;
	typedef struct packed {
		logic       hang;
		logic [3:0] sp;
		logic [1:0] ics_cnt;
	} pcsm_stat_t;
endpackage : pcsm_pkg

// ===== pcsm_core.sv
// Program counter, return and context stacks, and nibble data memory map.
// Assumes an APB master issues sequencer commands and memory accesses.
//
// Summary of operation
// [RL1] Program counter resets to address zero
// [RL2] Program counter is plain binary word counter
// [RL3] Direct call reaches lowest 2048 words only
// [RL4] Indirect operations reach the whole program memory
// [RL5] Stack pointer four bits, top bit zero
// [RL6] Five return entries, three context entries
// [RL7] Entry takes return address or address register
// [RL8] Hang-up low when pointer six or more
// [RL9] Interrupt saves and restores bank and status
// [RL10] Context stack overflow discards oldest saved context
// [RL11] Calls decrement pointer, returns increment it
// [RL12] Interrupt decrements pointer and increments context count, interrupt return reverses both
// [RL13] Seven-bit nibble address: row and column
// [RL14] System registers at 74H through 7FH
// [RL15] Transfer buffer 0CH-0FH, resets to 0320H
// [RL16] Row pointer at 7CH is stored and read back only
// [RL17] Port registers bank zero; bank one writes ignored
// [RL18] Small variants have bank zero only
// [RL19] General storage 111 and 112 nibbles
// [RL20] System registers shared across banks
// [RL21] Board ties hang-up output to reset
// [RL22] Stack pointer resets to five
// [RL23] Pointer five to seven addresses nothing
`timescale 1ns/1ps
`include "pcsm_consts.svh"
module pcsm_core
	import pcsm_pkg::*;
(
	// Clock and reset
	input  wire logic        pclk,
	input  wire logic        presetn,
	// APB slave
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	// Hang-up open-drain pin
	output logic             hang_up_output_o,
	output logic             hang_up_output_oe,
	// Program counter to program memory
	output logic      [12:0] program_counter
);
	//------------------------------------------------------------
	// Bus decode
	//------------------------------------------------------------
	logic        wr_en;
	logic        rd_en;
	logic        hit;
	assign wr_en   = psel && penable && pwrite;
	assign rd_en   = psel && penable && !pwrite;
	assign pready  = 1'b1;
	assign hit     = (paddr == `PCSM_APB_CTRL) || (paddr == `PCSM_APB_CMD)
	              || (paddr == `PCSM_APB_PC) || (paddr == `PCSM_APB_STAT)
	              || (paddr == `PCSM_APB_MEMA) || (paddr == `PCSM_APB_MEMD);
	assign pslverr = psel && penable && !hit;

	//------------------------------------------------------------
	// Configuration and state
	//------------------------------------------------------------
	pcsm_cfg_t   cfg_reg;
	pcsm_op_t    op;
	logic        cmd_go;
	logic [12:0] cmd_target;
	logic [12:0] pc_mask;
	logic [12:0] ret_addr;
	logic [15:0] address_register;
	logic [3:0]  return_stack_pointer;
	logic [1:0]  ics_cnt_reg;
	logic [12:0] return_address_stack [0:`PCSM_RAS_DEPTH-1];
	logic [5:0]  interrupt_context_stack [0:`PCSM_ICS_DEPTH-1];
	logic [3:0]  ram_reg [0:255];
	logic [7:0]  mem_addr_reg;
	logic [3:0]  bank_sel;
	logic [3:0]  program_status_word;
	logic [2:0]  working_row_pointer;
	logic        sp_valid;
	logic [2:0]  sp_idx;
	logic [2:0]  sp_dec_idx;

	assign cmd_go     = wr_en && (paddr == `PCSM_APB_CMD);
	assign op         = cmd_go ? pcsm_op_t'(pwdata[3:0]) : PCSM_OP_NONE;
	assign cmd_target = pwdata[28:16];
	// Width follows the variant: 11 or 13 significant bits
	assign pc_mask = cfg_reg.wide_rom ? 13'h1fff : 13'h07ff; // [RL2]
	assign ret_addr = (program_counter + 13'h0001) & pc_mask;

	// Variant straps held in software-written control
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cfg_reg <= '0;
		end else if (wr_en && (paddr == `PCSM_APB_CTRL)) begin
			cfg_reg <= pcsm_cfg_t'(pwdata[1:0]);
		end
	end

	//------------------------------------------------------------
	// Program counter
	//------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			program_counter <= `PCSM_PC_RESET; // [RL1]
		end else begin
			case (op)
				PCSM_OP_STEP: program_counter <= ret_addr; // [RL2]
				// Direct call target is forced into the low 2K words
				PCSM_OP_CALL: program_counter <= cmd_target & `PCSM_CALL_LIMIT; // [RL3]
				PCSM_OP_ICALL, PCSM_OP_IBR: program_counter <= address_register[12:0] & pc_mask; // [RL4]
				PCSM_OP_INT: program_counter <= cmd_target & pc_mask;
				PCSM_OP_RET, PCSM_OP_IRET: program_counter <= sp_valid ?
					return_address_stack[sp_idx] : program_counter;
				PCSM_OP_RETURN_AND_SKIP: program_counter <= sp_valid ?
					((return_address_stack[sp_idx] + 13'h0001) & pc_mask) : program_counter;
				PCSM_OP_TRD2: program_counter <= sp_valid ?
					return_address_stack[sp_idx] : program_counter;
				default: program_counter <= program_counter;
			endcase
		end
	end

	//------------------------------------------------------------
	// Return stack pointer
	//------------------------------------------------------------
	// Entries live at pointer values 0..4; 5..7 hold nothing
	assign sp_valid   = (return_stack_pointer < 4'h5); // [RL23]
	assign sp_idx     = return_stack_pointer[2:0];
	assign sp_dec_idx = return_stack_pointer[2:0] - 3'h1;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			return_stack_pointer <= `PCSM_SP_RESET; // [RL22]
		end else begin
			case (op)
				PCSM_OP_CALL, PCSM_OP_ICALL, PCSM_OP_TRD1, PCSM_OP_PUSH, PCSM_OP_INT:
					return_stack_pointer <= {1'b0, sp_dec_idx}; // [RL5] [RL11] [RL12]
				PCSM_OP_RET, PCSM_OP_RETURN_AND_SKIP, PCSM_OP_TRD2, PCSM_OP_POP, PCSM_OP_IRET:
					return_stack_pointer <= {1'b0, sp_idx + 3'h1}; // [RL5] [RL11] [RL12]
				default: return_stack_pointer <= return_stack_pointer;
			endcase
		end
	end

	//------------------------------------------------------------
	// Return address stack
	//------------------------------------------------------------
	// Pushes below entry zero wrap the pointer and store nothing
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			for (int i = 0; i < `PCSM_RAS_DEPTH; i++) begin
				return_address_stack[i] <= '0;
			end
		end else if (sp_dec_idx < 3'h5) begin
			case (op)
				PCSM_OP_CALL, PCSM_OP_ICALL, PCSM_OP_TRD1, PCSM_OP_INT:
					return_address_stack[sp_dec_idx] <= ret_addr; // [RL6] [RL7]
				PCSM_OP_PUSH:
					return_address_stack[sp_dec_idx] <= address_register[12:0] & pc_mask; // [RL7]
				default: ;
			endcase
		end
	end

	// Address register reloaded by pop; also writable as nibbles
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			address_register <= '0;
		end else if (op == PCSM_OP_POP && sp_valid) begin
			address_register <= {3'h0, return_address_stack[sp_idx]};
		end else if (wr_en && paddr == `PCSM_APB_MEMD && mem_addr_reg[6:2] == 5'h1d) begin
			address_register[4*(3-mem_addr_reg[1:0]) +: 4] <= pwdata[3:0];
		end
	end

	// Stack overflow: drive low when pointer is 6 or 7
	assign hang_up_output_o  = 1'b0;
	assign hang_up_output_oe = (return_stack_pointer >= `PCSM_SP_HANG); // [RL8]

	//------------------------------------------------------------
	// Interrupt context stack
	//------------------------------------------------------------
	// Circular store: the fourth nested save overwrites the oldest
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ics_cnt_reg <= '0;
			for (int j = 0; j < `PCSM_ICS_DEPTH; j++) begin
				interrupt_context_stack[j] <= '0;
			end
		end else if (op == PCSM_OP_INT) begin
			interrupt_context_stack[ics_cnt_reg] <= {bank_sel[1:0], program_status_word}; // [RL9]
			ics_cnt_reg <= (ics_cnt_reg == 2'h2) ? 2'h0 : ics_cnt_reg + 2'h1; // [RL10] [RL12]
		end else if (op == PCSM_OP_IRET) begin
			ics_cnt_reg <= (ics_cnt_reg == 2'h0) ? 2'h2 : ics_cnt_reg - 2'h1; // [RL12]
		end
	end

	//------------------------------------------------------------
	// Data memory map
	//------------------------------------------------------------
	logic [1:0] iret_idx;
	logic [6:0] la;
	logic       bk;
	logic [3:0] rd_nib;
	assign iret_idx = (ics_cnt_reg == 2'h0) ? 2'h2 : ics_cnt_reg - 2'h1;
	assign la = mem_addr_reg[6:0]; // [RL13]
	assign bk = mem_addr_reg[7] && cfg_reg.two_banks; // [RL18]

	// System registers: bank, status and row pointer live once
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			bank_sel            <= '0;
			program_status_word <= '0;
			working_row_pointer <= '0;
		end else if (op == PCSM_OP_IRET) begin
			{bank_sel[1:0], program_status_word} <= interrupt_context_stack[iret_idx]; // [RL9]
			bank_sel[3:2] <= 2'h0;
		end else if (wr_en && paddr == `PCSM_APB_MEMD && la >= `PCSM_SYS_LO) begin // [RL14] [RL20]
			if (la[3:0] == `PCSM_BANK_OFS) begin
				bank_sel <= {3'h0, pwdata[0] & cfg_reg.two_banks};
			end else if (la[3:0] == `PCSM_PSW_OFS) begin
				program_status_word <= pwdata[3:0];
			end else if (la[3:0] == `PCSM_RP_OFS) begin
				working_row_pointer <= pwdata[2:0]; // [RL16]
			end
		end
	end

	// Access address register; index 0x80 sets bank one
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			mem_addr_reg <= '0;
		end else if (wr_en && paddr == `PCSM_APB_MEMA) begin
			mem_addr_reg <= pwdata[7:0];
		end
	end

	// Nibble store; transfer buffer seeded at reset
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			for (int k = 0; k < 256; k++) begin
				ram_reg[k] <= '0;
			end
			ram_reg[8'h0c] <= 4'(`PCSM_DBF_RESET >> 12); // [RL15]
			ram_reg[8'h0d] <= 4'h3;
			ram_reg[8'h0e] <= 4'h2;
			ram_reg[8'h0f] <= 4'h0;
		end else if (wr_en && paddr == `PCSM_APB_MEMD && la < `PCSM_SYS_LO) begin // [RL19]
			if (!(bk && la >= `PCSM_PORT_LO)) begin // [RL17]
				ram_reg[{bk, la}] <= pwdata[3:0];
			end
		end
	end

	// Read path: system area shared, bank one ports mirror bank zero
	always_comb begin
		rd_nib = 4'h0;
		if (la >= `PCSM_SYS_LO) begin
			if (la[3:0] == `PCSM_BANK_OFS) begin
				rd_nib = bank_sel;
			end else if (la[3:0] == `PCSM_PSW_OFS) begin
				rd_nib = program_status_word;
			end else if (la[3:0] == `PCSM_RP_OFS) begin
				rd_nib = {1'b0, working_row_pointer};
			end else if (la[3:2] == 2'h1) begin
				rd_nib = address_register[4*(3-la[1:0]) +: 4];
			end
		end else if (bk && la >= `PCSM_PORT_LO) begin
			rd_nib = ram_reg[{1'b0, la}]; // [RL17]
		end else begin
			rd_nib = ram_reg[{bk, la}];
		end
	end

	//------------------------------------------------------------
	// Read data register
	//------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= '0;
		end else if (psel && !penable && !pwrite) begin
			if (paddr == `PCSM_APB_CTRL) begin
				prdata <= {30'h0, cfg_reg};
			end else if (paddr == `PCSM_APB_PC) begin
				prdata <= {19'h0, program_counter};
			end else if (paddr == `PCSM_APB_STAT) begin
				prdata <= {25'h0, hang_up_output_oe, return_stack_pointer, ics_cnt_reg};
			end else if (paddr == `PCSM_APB_MEMA) begin
				prdata <= {24'h0, mem_addr_reg};
			end else if (paddr == `PCSM_APB_MEMD) begin
				prdata <= {28'h0, rd_nib};
			end else begin
				prdata <= '0;
			end
		end
	end
endmodule : pcsm_core

// ===== pcsm_seq.sv
// Sequencer model: issues APB transfers to the program sequencing block.
// Assumes callers enter its task just after a rising pclk edge.
`timescale 1ns/1ps
module pcsm_seq (
	// Clock
	input  wire logic        pclk,
	// Request
	output logic             psel,
	output logic             penable,
	output logic             pwrite,
	output logic      [11:0] paddr,
	output logic      [31:0] pwdata,
	// Answer
	input  wire logic [31:0] prdata,
	input  wire logic        pready,
	input  wire logic        pslverr
);
	// Idle bus from time zero
	initial begin
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 12'h000;
		pwdata = 32'h0;
	end
	// One transfer; released data is inverted so a stale value never matches
	task automatic xf(input logic w, input logic [11:0] a, input logic [31:0] d,
		output logic [31:0] q, output logic e);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		q = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		pwdata <= ~d;
		@(posedge pclk);
	endtask : xf
endmodule : pcsm_seq

// ===== pcsm_core_monitor.sv
// Checker for the program sequencing block, bound to its top ports.
// Assumes the APB master holds a request until pready is seen.
`timescale 1ns/1ps
module pcsm_core_monitor
	import pcsm_pkg::*;
(
	// Clock and reset
	input wire logic        pclk,
	input wire logic        presetn,
	// APB
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic        pready,
	input wire logic        pslverr,
	// Outputs
	input wire logic        hang_up_output_o,
	input wire logic        hang_up_output_oe,
	input wire logic [12:0] program_counter
);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	// Command write in its access phase
	sequence s_cmd(op);
		psel && penable && pwrite && paddr == 12'h004 && pwdata[3:0] == op;
	endsequence
	sequence s_stat;
		psel && penable && !pwrite && paddr == 12'h00c;
	endsequence
	a_pc_at_reset: assert property ($rose(presetn) |-> program_counter == 13'h0)
		else $error("pc not zero after reset");
	a_pc_step_one: assert property (s_cmd(4'hc) |=>
		program_counter[10:0] == $past(program_counter[10:0]) + 11'h1)
		else $error("step did not add one");
	a_pc_needs_cmd: assert property (!$stable(program_counter) |-> $past(psel && pwrite
		&& paddr == 12'h004)) else $error("pc moved without a command");
	a_call_low_only: assert property (s_cmd(4'h1) |=>
		program_counter == {2'b00, $past(pwdata[26:16])}) else $error("call target wrong");
	a_vector_load: assert property (s_cmd(4'h9) |=>
		program_counter[10:0] == $past(pwdata[26:16])) else $error("vector not loaded");
	a_sp_top_zero: assert property (s_stat |-> !prdata[5])
		else $error("stack pointer top bit set");
	a_hang_level: assert property (s_stat |-> !hang_up_output_o &&
		hang_up_output_oe == (prdata[5:2] >= 4'h6) && prdata[6] == hang_up_output_oe)
		else $error("hang-up output wrong for pointer");
	a_hang_needs_cmd: assert property ($changed(hang_up_output_oe) |-> $past(psel && pwrite
		&& paddr == 12'h004)) else $error("hang-up moved without a command");
	a_bad_addr_err: assert property (psel && penable && (paddr > 12'h014 || paddr[1:0] != 2'b00)
		|-> pslverr && (pwrite || prdata == 32'h0)) else $error("unmapped access not refused");
endmodule : pcsm_core_monitor

// ===== test_pcsm_core.sv
// Testbench for the program sequencing block.
// Assumes the sequencer model drives APB and the checker is bound below.
`timescale 1ns/1ps
`include "pcsm_consts.svh"
module test_pcsm_core;
	import pcsm_pkg::*;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr, er;
	logic hang_up_output_o, hang_up_output_oe;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, q;
	logic [12:0] program_counter;
	logic [15:0] v;
	int errors, total_checks, i;
	pcsm_core pcsm_core_i(.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
		.prdata, .pready, .pslverr, .hang_up_output_o, .hang_up_output_oe, .program_counter);
	pcsm_seq pcsm_seq_i(.pclk, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
		.pslverr);
	initial begin
		pclk = 1'b0;
		forever #12.5 pclk = ~pclk;
	end
	// ----------------------------------------
	// Bus and compare helpers
	// ----------------------------------------
	task automatic chk(input logic [31:0] s, input logic [31:0] e);
		total_checks++;
		if (s !== e) begin
			errors++;
			$display("unexpected at %0t: seen %h expected %h", $time, s, e);
		end
	endtask : chk
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		pcsm_seq_i.xf(1'b1, a, d, q, er);
	endtask : wr
	task automatic rd(input logic [11:0] a, input logic [31:0] e, input logic [31:0] m = '1);
		pcsm_seq_i.xf(1'b0, a, 32'h0, q, er);
		chk(q & m, e);
	endtask : rd
	task automatic cmd(input pcsm_op_t op, input logic [12:0] t);
		wr(`PCSM_APB_CMD, {3'h0, t, 12'h000, op});
	endtask : cmd
	task automatic mw(input logic b, input logic [6:0] a, input logic [3:0] n);
		wr(`PCSM_APB_MEMA, {24'h0, b, a});
		wr(`PCSM_APB_MEMD, {28'h0, n});
	endtask : mw
	task automatic mr(input logic b, input logic [6:0] a, input logic [3:0] n);
		wr(`PCSM_APB_MEMA, {24'h0, b, a});
		rd(`PCSM_APB_MEMD, {28'h0, n});
	endtask : mr
	task automatic rst();
		presetn <= 1'b0;
		repeat (12) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
	endtask : rst
	task automatic results();
		$display("checks %0d mismatches %0d", total_checks, errors);
		if (errors == 0 && total_checks > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask : results
	// Hang guard, far beyond the roughly 400 cycles the tests need
	initial begin
		repeat (20000) @(posedge pclk);
		errors++;
		$display("watchdog expired");
		results();
	end
	initial begin
		presetn = 1'b0;
		errors = 0;
		total_checks = 0;
		v = 16'h0320;
		rst();
		rd(`PCSM_APB_PC, 32'h0);
		rd(`PCSM_APB_STAT, 32'h14);
		for (i = 0; i < 4; i++) mr(1'b0, 7'h0c + i[6:0], v[15-4*i -: 4]);
		wr(`PCSM_APB_CTRL, 32'h0);
		mw(1'b0, 7'h79, 4'h1);
		mr(1'b0, 7'h79, 4'h0);
		$display("reset test done");
		wr(`PCSM_APB_CTRL, 32'h3);
		cmd(PCSM_OP_CALL, 13'h1abc);
		rd(`PCSM_APB_PC, 32'h02bc);
		cmd(PCSM_OP_STEP, 13'h0);
		rd(`PCSM_APB_PC, 32'h02bd);
		mw(1'b0, 7'h74, 4'h1);
		mw(1'b0, 7'h75, 4'hf);
		mw(1'b0, 7'h76, 4'h0);
		mw(1'b0, 7'h77, 4'h0);
		cmd(PCSM_OP_IBR, 13'h1f00);
		rd(`PCSM_APB_PC, 32'h1f00);
		mw(1'b0, 7'h76, 4'hf);
		mw(1'b0, 7'h77, 4'he);
		cmd(PCSM_OP_ICALL, 13'h1ffe);
		rd(`PCSM_APB_PC, 32'h1ffe);
		cmd(PCSM_OP_RETURN_AND_SKIP, 13'h0);
		rd(`PCSM_APB_PC, 32'h1f02);
		cmd(PCSM_OP_TRD1, 13'h0);
		rd(`PCSM_APB_STAT, 32'h0c, 32'h7c);
		cmd(PCSM_OP_TRD2, 13'h0);
		for (i = 0; i < 4; i++) mw(1'b0, 7'h74 + i[6:0], 4'(i + 1));
		cmd(PCSM_OP_PUSH, 13'h0);
		mw(1'b0, 7'h77, 4'hf);
		cmd(PCSM_OP_POP, 13'h0);
		mr(1'b0, 7'h77, 4'h4);
		rd(`PCSM_APB_STAT, 32'h10, 32'h7c);
		$display("flow test done");
		for (i = 1; i < 5; i++) begin
			mw(1'b0, 7'h79, 4'(i & 1));
			mw(1'b0, 7'h7f, 4'(i));
			cmd(PCSM_OP_INT, 13'h0010);
		end
		rd(`PCSM_APB_STAT, 32'h00, 32'h7c);
		rd(`PCSM_APB_PC, 32'h0010);
		v = 16'h4324;
		for (i = 0; i < 4; i++) begin
			cmd(PCSM_OP_IRET, 13'h0);
			mr(1'b0, 7'h7f, v[15-4*i -: 4]);
			mr(1'b0, 7'h79, {3'h0, v[12-4*i]});
		end
		rd(`PCSM_APB_STAT, 32'h10, 32'h7c);
		$display("interrupt test done");
		mw(1'b0, 7'h70, 4'h5);
		mw(1'b1, 7'h70, 4'ha);
		mr(1'b1, 7'h70, 4'h5);
		mw(1'b0, 7'h7c, 4'h3);
		mr(1'b1, 7'h7c, 4'h3);
		mw(1'b1, 7'h10, 4'h9);
		mw(1'b0, 7'h1a, 4'h6);
		mr(1'b1, 7'h10, 4'h9);
		mr(1'b0, 7'h1a, 4'h6);
		rd(12'h018, 32'h0);
		chk({31'h0, er}, 32'h1);
		$display("memory test done");
		for (i = 0; i < 5; i++) cmd(PCSM_OP_CALL, 13'h0100);
		rd(`PCSM_APB_STAT, 32'h5c, 32'h7c);
		cmd(PCSM_OP_CALL, 13'h0100);
		rd(`PCSM_APB_STAT, 32'h58, 32'h7c);
		chk({31'h0, hang_up_output_oe}, 32'h1);
		rst();
		rd(`PCSM_APB_PC, 32'h0);
		rd(`PCSM_APB_STAT, 32'h14);
		$display("overflow test done");
		results();
	end
endmodule : test_pcsm_core
bind pcsm_core pcsm_core_monitor pcsm_core_monitor_i(.pclk, .presetn, .psel, .penable,
	.pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .hang_up_output_o,
	.hang_up_output_oe, .program_counter);
